// ===== hw/adcc_ctrl.sv
// converter sample and conversion sequencer with its register slave
`timescale 1ns/1ps
module adcc_ctrl #(
	parameter int CONV_PERIODS = adcc_pkg::CONV_TADS
) (
	// clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// axi4-lite write
	input wire logic [adcc_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [adcc_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// hardware trigger pin
	input wire logic trigger_in,
	// analog front end and dma side
	output logic sampling,
	output logic converting,
	output logic [3:0] chan_sample_mask,
	output logic vref_pos_ext,
	output logic vref_neg_ext,
	output logic input_set_b,
	output logic scan_step,
	output logic conv_done_pulse,
	output logic dma_step,
	output logic buffer_half_status
);
	import adcc_pkg::*;

	// ***************************************
	// register storage
	// ***************************************
	logic twelve_bit_mode_r, simultaneous_sample_sel_r, auto_sample_start_r, done_r;
	logic [2:0] trigger_source_sel_r;
	logic [2:0] reference_config_r;
	logic input_scan_enable_r, buffer_split_mode_r, alternate_input_mode_r;
	logic [1:0] channel_count_sel_r;
	logic [3:0] conversions_per_interrupt_r;
	logic internal_rc_clock_sel_r;
	logic [4:0] auto_sample_time_r;
	logic [7:0] conv_clock_divider_r;
	adcc_state_t state_r, state_nxt;

	// bus slave state
	logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r, wdata_q;
	logic [3:0] wstrb_q;
	logic [ADDR_W-1:0] awaddr_q;

	// sequencer state
	logic [4:0] sample_enable_bit_cnt_r;
	logic [7:0] conv_cnt_r;
	logic [3:0] op_cnt_r;
	logic [1:0] chan_idx_r;
	logic trig_s1, trig_s2, trig_s3;
	logic sampling_r, converting_r, vref_pos_r, vref_neg_r, set_b_r;
	logic scan_step_r, done_pulse_r, dma_step_r, buf_half_r;
	logic [3:0] mask_r;
	logic tad_tick;

	// ***************************************
	// register views and write decode
	// ***************************************
	// in 12-bit mode these bits do not exist, so both the view and the effect are forced low
	wire logic simultaneous_sample_sel_eff = simultaneous_sample_sel_r && !twelve_bit_mode_r;
	wire logic [1:0] chps_eff = twelve_bit_mode_r ? 2'b00 : channel_count_sel_r;
	wire logic is_sample_enable_bit = (state_r == ADCC_SAMPLE_ENABLE_BIT);
	wire logic [15:0] ctrl1_view = {5'h00, twelve_bit_mode_r, 2'b00, trigger_source_sel_r, 1'b0,
		simultaneous_sample_sel_eff, auto_sample_start_r, is_sample_enable_bit, done_r};
	wire logic [15:0] ctrl2_view = {reference_config_r, 2'b00, input_scan_enable_r, chps_eff,
		buf_half_r, 1'b0, conversions_per_interrupt_r, buffer_split_mode_r,
		alternate_input_mode_r};
	wire logic [15:0] ctrl3_view = {internal_rc_clock_sel_r, 2'b00, auto_sample_time_r,
		conv_clock_divider_r};

	wire logic wr_go = !awready_r && !wready_r && !bvalid_r;
	wire logic wr_c1 = wr_go && (awaddr_q == OFS_CTRL1);
	wire logic wr_c2 = wr_go && (awaddr_q == OFS_CTRL2);
	wire logic wr_c3 = wr_go && (awaddr_q == OFS_CTRL3);
	wire logic wr_bad = wr_go && !wr_c1 && !wr_c2 && !wr_c3;
	wire logic [15:0] c1_new = adcc_merge(ctrl1_view, wdata_q, wstrb_q);
	wire logic [15:0] c2_new = adcc_merge(ctrl2_view, wdata_q, wstrb_q);
	wire logic [15:0] c3_new = adcc_merge(ctrl3_view, wdata_q, wstrb_q);
	wire logic lane0 = wr_c1 && wstrb_q[0];
	wire logic sw_sample_enable_bit_wr1 = lane0 && wdata_q[C1_SAMPLE_ENABLE_BIT];
	wire logic sw_sample_enable_bit_wr0 = lane0 && !wdata_q[C1_SAMPLE_ENABLE_BIT];
	wire logic sw_done_clr = lane0 && !wdata_q[C1_DONE];

	wire logic ar_hs = arvalid && arready_r;
	wire logic ar_c1 = (araddr == OFS_CTRL1);
	wire logic ar_c2 = (araddr == OFS_CTRL2);
	wire logic ar_c3 = (araddr == OFS_CTRL3);
	wire logic [15:0] rd_mux = ar_c1 ? ctrl1_view : ar_c2 ? ctrl2_view : ar_c3 ? ctrl3_view : RST_16;

	// ***************************************
	// sequencer decode
	// ***************************************
	wire logic trig_edge = trig_s2 && !trig_s3;
	wire logic manual = (trigger_source_sel_r == TRIG_MANUAL);
	wire logic auto_conv = (trigger_source_sel_r == TRIG_AUTO);
	wire logic samc_hit = (sample_enable_bit_cnt_r == auto_sample_time_r);
	// only the selected source may end sampling
	wire logic sample_enable_bit_end = is_sample_enable_bit && (manual ? sw_sample_enable_bit_wr0 : auto_conv ? samc_hit : trig_edge);
	wire logic conv_end = (state_r == ADCC_CONV) && tad_tick &&
		(conv_cnt_r == 8'(CONV_PERIODS - 1));
	wire logic conv_start = sample_enable_bit_end;
	wire logic op_hit = (op_cnt_r == conversions_per_interrupt_r);
	wire logic sim_on = simultaneous_sample_sel_eff && (chps_eff != 2'b00);
	wire logic [3:0] en_mask = adcc_en_mask(chps_eff);
	wire logic [1:0] idx_max = chps_eff[1] ? 2'd3 : (chps_eff[0] ? 2'd1 : 2'd0);
	wire logic tad_restart = (state_nxt != state_r);
	// the mask must show the channel of the sample being started, not the one just converted
	wire logic [1:0] chan_idx_nxt = !conv_end ? chan_idx_r :
		(sim_on || chan_idx_r >= idx_max) ? 2'd0 : chan_idx_r + 2'd1;
	wire logic [3:0] mask_nxt = (state_nxt != ADCC_SAMPLE_ENABLE_BIT) ? 4'h0 :
		sim_on ? en_mask : 4'(4'h1 << chan_idx_nxt);

	// next phase of the sample/hold sequence
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ADCC_HOLD: begin
				if (auto_sample_start_r || sw_sample_enable_bit_wr1) begin
					state_nxt = ADCC_SAMPLE_ENABLE_BIT;
				end
			end
			ADCC_SAMPLE_ENABLE_BIT: begin
				if (sample_enable_bit_end) begin
					state_nxt = ADCC_CONV;
				end
			end
			ADCC_CONV: begin
				if (conv_end) begin
					state_nxt = auto_sample_start_r ? ADCC_SAMPLE_ENABLE_BIT : ADCC_HOLD;
				end
			end
			default: state_nxt = ADCC_HOLD;
		endcase
	end

	// ***************************************
	// conversion clock
	// ***************************************
	adcc_tad_gen u_tad (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.restart(tad_restart),
		.use_rc(internal_rc_clock_sel_r),
		.divider(conv_clock_divider_r),
		.tick(tad_tick)
	);

	// ***************************************
	// bus slave
	// ***************************************
	// one write and one read in flight; write data and address may arrive in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			awaddr_q <= '0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else if (ce) begin
			if (awvalid && awready_r) begin
				awaddr_q <= awaddr;
				awready_r <= 1'b0;
			end
			if (wvalid && wready_r) begin
				wdata_q <= wdata;
				wstrb_q <= wstrb;
				wready_r <= 1'b0;
			end
			if (wr_go) begin
				bvalid_r <= 1'b1;
				bresp_r <= wr_bad ? RESP_SLVERR : RESP_OKAY;
			end
			if (bvalid_r && bready) begin
				bvalid_r <= 1'b0;
				awready_r <= 1'b1;
				wready_r <= 1'b1;
			end
		end
	end

	// read data is latched at the address handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= RESP_OKAY;
		end else if (ce) begin
			if (ar_hs) begin
				arready_r <= 1'b0;
				rvalid_r <= 1'b1;
				rdata_r <= {16'h0000, rd_mux};
				rresp_r <= (ar_c1 || ar_c2 || ar_c3) ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid_r && rready) begin
				rvalid_r <= 1'b0;
				arready_r <= 1'b1;
			end
		end
	end

	// ***************************************
	// configuration registers
	// ***************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{twelve_bit_mode_r, trigger_source_sel_r} <= 4'h0;
			{simultaneous_sample_sel_r, auto_sample_start_r} <= 2'b00;
			{reference_config_r, input_scan_enable_r, channel_count_sel_r} <= 6'h00;
			{conversions_per_interrupt_r, buffer_split_mode_r, alternate_input_mode_r} <= 6'h00;
			{internal_rc_clock_sel_r, auto_sample_time_r, conv_clock_divider_r} <= 14'h0000;
		end else if (ce) begin
			if (wr_c1) begin
				twelve_bit_mode_r <= c1_new[C1_TWELVE];
				trigger_source_sel_r <= c1_new[C1_TRIG_LO +: 3];
				simultaneous_sample_sel_r <= c1_new[C1_SIMULTANEOUS_SAMPLE_SEL] && !c1_new[C1_TWELVE];
				auto_sample_start_r <= c1_new[C1_AUTO_SAMPLE_START];
			end
			if (wr_c2) begin
				reference_config_r <= c2_new[C2_VCFG_LO +: 3];
				input_scan_enable_r <= c2_new[C2_SCAN];
				channel_count_sel_r <= c2_new[C2_CHPS_LO +: 2];
				conversions_per_interrupt_r <= c2_new[C2_SMPI_LO +: 4];
				buffer_split_mode_r <= c2_new[C2_BUFFER_SPLIT_MODE];
				alternate_input_mode_r <= c2_new[C2_ALTERNATE_INPUT_MODE];
			end
			if (wr_c3) begin
				internal_rc_clock_sel_r <= c3_new[C3_INTERNAL_RC_CLOCK_SEL];
				auto_sample_time_r <= c3_new[C3_SAMC_LO +: 5];
				conv_clock_divider_r <= c3_new[C3_ADCS_LO +: 8];
			end
		end
	end

	// ***************************************
	// sequencer
	// ***************************************
	// trigger pin is asynchronous: two flops before use, third for the edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{trig_s1, trig_s2, trig_s3} <= 3'b000;
		end else if (ce) begin
			{trig_s1, trig_s2, trig_s3} <= {trigger_in, trig_s1, trig_s2};
		end
	end

	// phase, counters and done flag; completion beats a same-cycle software clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= ADCC_HOLD;
			sample_enable_bit_cnt_r <= 5'h00;
			conv_cnt_r <= 8'h00;
			done_r <= 1'b0;
		end else if (ce) begin
			state_r <= state_nxt;
			sample_enable_bit_cnt_r <= tad_restart ? 5'h00 : (tad_tick && !samc_hit) ? sample_enable_bit_cnt_r + 5'h01 : sample_enable_bit_cnt_r;
			conv_cnt_r <= tad_restart ? 8'h00 : tad_tick ? conv_cnt_r + 8'h01 : conv_cnt_r;
			done_r <= conv_end ? 1'b1 : (conv_start || sw_done_clr) ? 1'b0 : done_r;
		end
	end

	// per-operation bookkeeping: dma steps, buffer halves, input sets, scan
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			op_cnt_r <= 4'h0;
			chan_idx_r <= 2'd0;
			buf_half_r <= 1'b0;
			set_b_r <= 1'b0;
			{scan_step_r, done_pulse_r, dma_step_r} <= 3'b000;
		end else if (ce) begin
			done_pulse_r <= conv_end;
			dma_step_r <= conv_end && op_hit;
			scan_step_r <= conv_end && input_scan_enable_r && !set_b_r;
			if (conv_end) begin
				op_cnt_r <= op_hit ? 4'h0 : op_cnt_r + 4'h1;
				chan_idx_r <= chan_idx_nxt;
				set_b_r <= alternate_input_mode_r && !set_b_r;
				if (op_hit) begin
					buf_half_r <= buffer_split_mode_r && !buf_half_r;
				end
			end
			if (!alternate_input_mode_r) begin
				set_b_r <= 1'b0;
			end
			if (!buffer_split_mode_r) begin
				buf_half_r <= 1'b0;
			end
		end
	end

	// front-end outputs, each from its own flop
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{sampling_r, converting_r, vref_pos_r, vref_neg_r} <= 4'h0;
			mask_r <= 4'h0;
		end else if (ce) begin
			sampling_r <= (state_nxt == ADCC_SAMPLE_ENABLE_BIT);
			converting_r <= (state_nxt == ADCC_CONV);
			mask_r <= mask_nxt;
			vref_pos_r <= !reference_config_r[2] && reference_config_r[0];
			vref_neg_r <= !reference_config_r[2] && reference_config_r[1];
		end
	end

	assign {awready, wready, bvalid, bresp} = {awready_r, wready_r, bvalid_r, bresp_r};
	assign {arready, rvalid, rdata, rresp} = {arready_r, rvalid_r, rdata_r, rresp_r};
	assign {sampling, converting, chan_sample_mask} = {sampling_r, converting_r, mask_r};
	assign {vref_pos_ext, vref_neg_ext, input_set_b} = {vref_pos_r, vref_neg_r, set_b_r};
	assign {scan_step, conv_done_pulse, dma_step} = {scan_step_r, done_pulse_r, dma_step_r};
	assign buffer_half_status = buf_half_r;

	// ***************************************
	// checks
	// ***************************************
	property p_sim_mask;
		@(posedge aclk) disable iff (!aresetn) ce && state_nxt == ADCC_SAMPLE_ENABLE_BIT && sim_on |=> mask_r == $past(en_mask);
	endproperty
	a_sim_mask: assert property (p_sim_mask) else $error("simultaneous mask wrong");
	property p_twelve_rd;
		@(posedge aclk) disable iff (!aresetn) ce && ar_hs && ar_c1 && twelve_bit_mode_r |=> !rdata_r[C1_SIMULTANEOUS_SAMPLE_SEL];
	endproperty
	a_twelve_rd: assert property (p_twelve_rd) else $error("simultaneous_sample_sel visible in 12-bit");
	property p_auto_sample_start;
		@(posedge aclk) disable iff (!aresetn) ce && conv_end && auto_sample_start_r |=> state_r == ADCC_SAMPLE_ENABLE_BIT && sampling;
	endproperty
	a_auto_sample_start: assert property (p_auto_sample_start) else $error("no auto restart");
	property p_hold;
		@(posedge aclk) disable iff (!aresetn)
			ce && state_r == ADCC_HOLD && !auto_sample_start_r && !sw_sample_enable_bit_wr1 |=> state_r == ADCC_HOLD;
	endproperty
	a_hold: assert property (p_hold) else $error("left hold unasked");
	property p_sample_enable_bit_rd;
		@(posedge aclk) disable iff (!aresetn) ce && ar_hs && ar_c1 |=> rdata_r[C1_SAMPLE_ENABLE_BIT] == $past(is_sample_enable_bit);
	endproperty
	a_sample_enable_bit_rd: assert property (p_sample_enable_bit_rd) else $error("sample bit view wrong");
	property p_manual;
		@(posedge aclk) disable iff (!aresetn) ce && is_sample_enable_bit && manual && !sw_sample_enable_bit_wr0 |=> is_sample_enable_bit;
	endproperty
	a_manual: assert property (p_manual) else $error("manual sampling ended by hardware");
	property p_done;
		@(posedge aclk) disable iff (!aresetn) ce && conv_end |=> done_r && conv_done_pulse;
	endproperty
	a_done: assert property (p_done) else $error("done not set");
	property p_done_clr;
		@(posedge aclk) disable iff (!aresetn) ce && conv_start |=> !done_r && converting;
	endproperty
	a_done_clr: assert property (p_done_clr) else $error("done not cleared at start");
	property p_dma;
		@(posedge aclk) disable iff (!aresetn) ce && conv_end && op_hit |=> dma_step && op_cnt_r == 4'h0;
	endproperty
	a_dma: assert property (p_dma) else $error("dma step missing");
	property p_ref;
		@(posedge aclk) disable iff (!aresetn) ce && reference_config_r[2] |=> !vref_pos_ext && !vref_neg_ext;
	endproperty
	a_ref: assert property (p_ref) else $error("1xx must pick rails");
	c_auto: cover property (@(posedge aclk) conv_end && auto_conv);
	c_dma: cover property (@(posedge aclk) dma_step && buffer_half_status);
	c_sim: cover property (@(posedge aclk) sampling && chan_sample_mask == 4'hF);
endmodule : adcc_ctrl

// ===== hw/adcc_pkg.sv
// constants, types and helpers shared by the converter control block
//
// Notes on behaviour
// - simultaneous mode samples ch0-3 (count 1x) or ch0-1 (count 01) together, else sequential
// - in 12-bit mode the simultaneous-sample select reads zero and has no effect
// - auto-start re-enters sampling right after a conversion and sets the sample bit
// - without auto-start, hold lasts until software writes one to the sample bit
// - sample bit reads one while sampling, zero while holding
// - trigger 000: only a software write of zero ends sampling
// - other triggers: hardware clears the sample bit and starts conversion
// - done bit sets when a conversion completes, zero before and during
// - software may clear done, writing one is ignored, conversion unaffected
// - done clears automatically when a new conversion starts
// - reference field 000 rails, 001 ext plus, 010 ext minus, 011 both, 1xx rails
// - scan enable steps the scanned ch0 positive input during input set A only
// - channel count 00 ch0, 01 ch0-1; reads zero in 12-bit mode
// - buffer-half status reads one while filling the second half
// - field N steps the dma address after every N+1 completed operations
// - split mode alternates buffer halves per step, otherwise always first half
// - alternate mode toggles input sets A and B per sample, else always A
// - internal rc clock ignores the divider field
package adcc_pkg;
	// ***************************************
	// register map
	// ***************************************
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] OFS_CTRL1 = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_CTRL2 = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_CTRL3 = 4'h8;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam logic [15:0] RST_16 = 16'h0000;

	// control one field positions
	localparam int C1_TWELVE = 10;
	localparam int C1_TRIG_LO = 5;
	localparam int C1_SIMULTANEOUS_SAMPLE_SEL = 3;
	localparam int C1_AUTO_SAMPLE_START = 2;
	localparam int C1_SAMPLE_ENABLE_BIT = 1;
	localparam int C1_DONE = 0;
	// control two field positions
	localparam int C2_VCFG_LO = 13;
	localparam int C2_SCAN = 10;
	localparam int C2_CHPS_LO = 8;
	localparam int C2_BUFFER_HALF_STATUS = 7;
	localparam int C2_SMPI_LO = 2;
	localparam int C2_BUFFER_SPLIT_MODE = 1;
	localparam int C2_ALTERNATE_INPUT_MODE = 0;
	// control three field positions
	localparam int C3_INTERNAL_RC_CLOCK_SEL = 15;
	localparam int C3_SAMC_LO = 8;
	localparam int C3_ADCS_LO = 0;

	// trigger source codes
	localparam logic [2:0] TRIG_MANUAL = 3'b000;
	localparam logic [2:0] TRIG_AUTO = 3'b111;

	// ***************************************
	// timing
	// ***************************************
	localparam int CLK_NS = 100;
	localparam int RC_TAD_NS = 250;
	localparam int RC_TAD_CYC = (RC_TAD_NS + CLK_NS - 1) / CLK_NS;
	localparam int CONV_TADS = 14;

	typedef enum logic [2:0] {
		ADCC_HOLD = 3'b001,
		ADCC_SAMPLE_ENABLE_BIT = 3'b010,
		ADCC_CONV = 3'b100
	} adcc_state_t;

	// byte-lane merge for a 16-bit register on a 32-bit bus
	function automatic logic [15:0] adcc_merge(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] st);
		adcc_merge = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
	endfunction : adcc_merge

	// channels in use for a channel-count code
	function automatic logic [3:0] adcc_en_mask(input logic [1:0] chps);
		adcc_en_mask = chps[1] ? 4'hF : (chps[0] ? 4'h3 : 4'h1);
	endfunction : adcc_en_mask
endpackage : adcc_pkg

// ===== hw/adcc_tad_gen.sv
// conversion clock tick generator
`timescale 1ns/1ps
module adcc_tad_gen (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// control
	input wire logic restart,
	input wire logic use_rc,
	input wire logic [7:0] divider,
	// tick out
	output logic tick
);
	import adcc_pkg::*;

	localparam logic [7:0] RC_LIMIT = 8'(RC_TAD_CYC - 1);
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	logic tick_r;
	wire logic [7:0] limit = use_rc ? RC_LIMIT : divider;
	wire logic wrap = (cnt_r == limit);

	assign cnt_nxt = (restart || wrap) ? 8'h00 : cnt_r + 8'h01;
	assign tick = tick_r;

	// one tick per conversion clock period, restarted with each phase
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= 8'h00;
			tick_r <= 1'b0;
		end else if (ce) begin
			cnt_r <= cnt_nxt;
			tick_r <= wrap && !restart;
		end
	end
endmodule : adcc_tad_gen

// ===== testbench/adcc_ctrl_bench.sv
// self-checking bench for the converter sequencer and its register slave
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin err_total++; $display("BAD %s exp %h got %h", n, e, s); end end
module adcc_ctrl_bench;
	import adcc_pkg::*;
	localparam int CONV = 2;
	logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
	logic [31:0] wdata = '0, rdata, d;
	logic [3:0] wstrb = 4'hF, delay = 4'h0, chan_sample_mask;
	logic [1:0] bresp, rresp, r, wr_resp;
	logic awready, wready, bvalid, arready, rvalid, trigger_in, fire = 1'b0;
	logic sampling, converting, vref_pos_ext, vref_neg_ext, input_set_b;
	logic scan_step, conv_done_pulse, dma_step, buffer_half_status;
	int err_total = 0, compares = 0, n_scan = 0, n_done, n_step;
	int i, m, n, k, dv, t, nn, d0, s0, c0;
	int mdl_n = 0, mdl_ops = 0, mdl_alt = 0;

	// ***************************************
	// clock, parts and helpers
	// ***************************************
	always #50 aclk = ~aclk;
	always @(posedge aclk) if (scan_step === 1'b1) n_scan++;
	// behavioural model: dma step and input set expected at every completion
	always @(posedge aclk) begin
		if (conv_done_pulse === 1'b1) begin
			`CHK("dma model", mdl_ops % (mdl_n + 1) == mdl_n, dma_step)
			`CHK("set model", mdl_alt != 0 && mdl_ops % 2 == 0, input_set_b)
			mdl_ops++;
		end
	end

	adcc_ctrl #(.CONV_PERIODS(CONV)) i_dut (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .trigger_in, .sampling, .converting, .chan_sample_mask, .vref_pos_ext,
		.vref_neg_ext, .input_set_b, .scan_step, .conv_done_pulse, .dma_step, .buffer_half_status);
	adcc_front_model i_front (.aclk, .aresetn, .fire, .delay, .conv_done_pulse, .dma_step, .trigger_in,
		.n_done, .n_step);

	task automatic give_verdict;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : give_verdict

	task automatic hang;
		err_total++;
		give_verdict();
	endtask : hang

	// address and data offered together, each dropped once taken
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (n = 0; n < 99; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		wr_resp = bresp;
		if (n == 99) hang();
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		for (n = 0; n < 99; n++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata;
		r = rresp;
		if (n == 99) hang();
	endtask : rd

	// counts edges until a design output shows the wanted level
	task automatic till(ref logic s, input logic v, output int c);
		for (c = 0; c < 3000 && s !== v; c++) @(posedge aclk);
		if (c == 3000) hang();
	endtask : till

	task automatic pulse_front;
		fire <= 1'b1;
		@(posedge aclk);
		fire <= 1'b0;
	endtask : pulse_front

	// ***************************************
	// scenarios
	// ***************************************
	initial begin
		void'($urandom(32'h6487));
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		// reset values, then the unmapped place refused on both paths
		for (i = 0; i < 4; i++) begin
			rd(ADDR_W'(4 * i));
			`CHK("reset value", {16'h0000, RST_16}, d)
			`CHK("read resp", (i == 3) ? RESP_SLVERR : RESP_OKAY, r)
		end
		wr(4'hC, 32'h0000_FFFF);
		`CHK("write resp", RESP_SLVERR, wr_resp)
		// every reference code
		for (i = 0; i < 8; i++) begin
			wr(OFS_CTRL2, 32'(i) << C2_VCFG_LO);
			repeat (2) @(posedge aclk);
			`CHK("vref pos", i == 1 || i == 3, vref_pos_ext)
			`CHK("vref neg", i == 2 || i == 3, vref_neg_ext)
		end
		// twelve-bit mode hides the channel fields
		wr(OFS_CTRL2, 32'h0000_0300);
		wr(OFS_CTRL1, 32'h0000_0408);
		rd(OFS_CTRL1);
		`CHK("simultaneous_sample_sel hidden", 32'h0000_0400, d)
		rd(OFS_CTRL2);
		`CHK("count hidden", 32'h0000_0000, d)
		wr(OFS_CTRL1, 32'h0000_0000);
		$display("test registers done");
		// manual conversions: random divider, rc clock with full divider, channel masks
		for (i = 0; i < 3; i++) begin
			dv = (i == 1) ? 255 : $urandom % 4;
			t = (i == 1) ? RC_TAD_CYC : dv + 1;
			wr(OFS_CTRL3, 32'((i == 1) << C3_INTERNAL_RC_CLOCK_SEL | dv));
			wr(OFS_CTRL2, 32'(i) << C2_CHPS_LO);
			wr(OFS_CTRL1, 32'h0000_000A);
			pulse_front();
			repeat (10) @(posedge aclk);
			`CHK("mask", (i == 0) ? 4'h1 : (i == 1) ? 4'h3 : 4'hF, chan_sample_mask)
			`CHK("held", 1'b1, sampling)
			rd(OFS_CTRL1);
			`CHK("sample_enable_bit bit", 1'b1, d[C1_SAMPLE_ENABLE_BIT])
			wr(OFS_CTRL1, 32'h0000_0008);
			till(converting, 1'b1, k);
			till(conv_done_pulse, 1'b1, k);
			`CHK("conv len", 1'b1, k >= t * (CONV - 1) && k <= t * (CONV + 1))
			repeat (3) @(posedge aclk);
			`CHK("stay hold", 1'b0, sampling)
			rd(OFS_CTRL1);
			`CHK("done set", 32'h0000_0009, d)
			wr(OFS_CTRL1, 32'h0000_0000);
			wr(OFS_CTRL1, 32'h0000_0001);
			rd(OFS_CTRL1);
			`CHK("done clear", 32'h0000_0000, d)
		end
		$display("test manual done");
		// pin trigger ends sampling by itself
		wr(OFS_CTRL2, 32'h0000_0000);
		wr(OFS_CTRL3, 32'h0000_0000);
		wr(OFS_CTRL1, 32'h0000_0042);
		repeat (10) @(posedge aclk);
		`CHK("wait pin", 1'b1, sampling)
		delay <= 4'($urandom % 8);
		pulse_front();
		till(converting, 1'b1, k);
		`CHK("pin start", 1'b1, k <= 16)
		rd(OFS_CTRL1);
		`CHK("sample_enable_bit cleared", 1'b0, d[C1_SAMPLE_ENABLE_BIT])
		till(conv_done_pulse, 1'b1, k);
		wr(OFS_CTRL1, 32'h0000_0000);
		$display("test pin done");
		// auto start, internal timer, split buffer, alternate sets and scanning
		nn = $urandom % 4;
		mdl_n = nn;
		mdl_ops = 0;
		mdl_alt = 1;
		wr(OFS_CTRL3, 32'h0000_0400);
		// two channels in sequence, so the one-hot mask must walk between them
		wr(OFS_CTRL2, 32'((1 << C2_SCAN) | (1 << C2_CHPS_LO) | (nn << C2_SMPI_LO) | 3));
		d0 = n_done;
		s0 = n_step;
		c0 = n_scan;
		wr(OFS_CTRL1, 32'h0000_00E4);
		for (m = 1; m <= 4; m++) begin
			for (k = 0; k < 3000 && n_done - d0 < m * (nn + 1); k++) @(posedge aclk);
			if (k == 3000) hang();
			repeat (2) @(posedge aclk);
			`CHK("dma steps", m, n_step - s0)
			`CHK("half", m % 2 == 1, buffer_half_status)
			`CHK("resample", 1'b1, sampling | converting)
			`CHK("seq mask", 4'(1 << (m * (nn + 1) % 2)), chan_sample_mask)
		end
		`CHK("scan steps", 2 * (nn + 1), n_scan - c0)
		wr(OFS_CTRL1, 32'h0000_0000);
		repeat (50) @(posedge aclk);
		$display("test auto done");
		give_verdict();
	end
endmodule : adcc_ctrl_bench

// ===== testbench/adcc_front_model.sv
// far-side model: hardware trigger source and completion counter
`timescale 1ns/1ps
module adcc_front_model (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bench request: one trigger after a chosen delay
	input wire logic fire,
	input wire logic [3:0] delay,
	// converter side
	input wire logic conv_done_pulse,
	input wire logic dma_step,
	output logic trigger_in,
	output int n_done,
	output int n_step
);
	int wait_r = -1;
	// the pulse leaves after its delay, so prompt and slow triggers both occur
	always @(posedge aclk) begin
		if (!aresetn) begin
			wait_r <= -1;
			n_done <= 0;
			n_step <= 0;
		end else begin
			wait_r <= fire ? int'(delay) : (wait_r >= 0 ? wait_r - 1 : -1);
			n_done <= n_done + int'(conv_done_pulse === 1'b1);
			n_step <= n_step + int'(dma_step === 1'b1);
		end
		trigger_in <= aresetn && wait_r == 0;
	end
endmodule : adcc_front_model
